// [logic/sswd_exec.sv]
`timescale 1ns/1ps
// execution of subtract, nibble swap and direction load
module sswd_exec
    import sswd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic instr_valid_i,
    input wire logic [sswd_pkg::INSTR_W-1:0] instr_i,
    input wire logic [sswd_pkg::DATA_W-1:0] file_rdata_i,
    output logic [sswd_pkg::ADDR_W-1:0] file_addr_o,
    output logic [sswd_pkg::DATA_W-1:0] file_wdata_o,
    output logic file_we_o,
    output logic [sswd_pkg::DATA_W-1:0] work_o,
    output logic carry_o,
    output logic digit_carry_flag_o,
    output logic zero_o,
    output logic [7:0] dir_a_o,
    output logic [7:0] dir_b_o,
    output logic [7:0] dir_c_o,
    output logic bad_dir_o
);
    import sswd_pkg::*;

    // ----------------------------------------
    // decode, combinational on the current word
    // ----------------------------------------
    sswd_op_t op; // decoded operation
    logic dest; // destination bit
    logic [4:0] addr; // file address field
    logic [2:0] sel; // direction selector
    logic [8:0] diff; // difference with borrow-out
    logic [4:0] ldiff; // low-nibble difference
    logic [7:0] result; // value to store
    logic [7:0] work_reg, work_next; // working register, read by the arithmetic below

    assign dest = instr_i[DEST_BIT];
    assign addr = instr_i[ADDR_LSB +: ADDR_W];
    assign sel = instr_i[SEL_W-1:0];
    // file address is combinational so the operand arrives this cycle
    assign file_addr_o = addr;

    always_comb
    begin
        op = SSWD_IDLE;
        if (instr_valid_i)
        begin
            if (instr_i[11:6] == OP_SUB_HI)
            begin
                op = SSWD_SUB;
            end
            else if (instr_i[11:6] == OP_SWAP_HI)
            begin
                op = SSWD_SWAP;
            end
            else if (instr_i[11:3] == OP_DIR_HI)
            begin
                op = SSWD_DIR;
            end
        end
    end

    // ----------------------------------------
    // arithmetic
    // ----------------------------------------
    // file minus working
    assign diff = {1'b0, file_rdata_i} - {1'b0, work_reg};
    assign ldiff = {1'b0, file_rdata_i[3:0]} - {1'b0, work_reg[3:0]};

    always_comb
    begin
        result = diff[7:0];
        if (op == SSWD_SWAP)
        begin
            result = {file_rdata_i[3:0], file_rdata_i[7:4]};
        end
    end

    // ----------------------------------------
    // state: working register, flags, file write
    // ----------------------------------------
    logic carry_reg, carry_next; // carry, set means no borrow
    logic dc_reg, dc_next; // digit carry flag
    logic zero_reg, zero_next; // zero flag
    logic [7:0] fw_reg, fw_next; // file write data
    logic fwe_reg, fwe_next; // file write strobe
    logic bad_reg, bad_next; // invalid direction selector
    logic [2:0] dir_load; // direction load strobes

    always_comb
    begin
        work_next = work_reg;
        carry_next = carry_reg;
        dc_next = dc_reg;
        zero_next = zero_reg;
        fw_next = fw_reg;
        fwe_next = 1'b0;
        bad_next = 1'b0;
        dir_load = 3'h0;
        unique case (op)
            SSWD_IDLE:
            begin
                fwe_next = 1'b0;
            end
            SSWD_SUB, SSWD_SWAP:
            begin
                if (dest)
                begin
                    fw_next = result;
                    fwe_next = 1'b1;
                end
                else
                begin
                    work_next = result;
                end
                if (op == SSWD_SUB)
                begin
                    carry_next = ~diff[8];
                    dc_next = ~ldiff[4];
                    zero_next = (diff[7:0] == 8'h00);
                end
            end
            SSWD_DIR:
            begin
                if (sel == DIR_SEL_A)
                begin
                    dir_load = 3'h1;
                end
                else if (sel == DIR_SEL_B)
                begin
                    dir_load = 3'h2;
                end
                else if (sel == DIR_SEL_C)
                begin
                    dir_load = 3'h4;
                end
                else
                begin
                    bad_next = 1'b1;
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            work_reg <= WORK_RESET;
            carry_reg <= FLAG_RESET;
            dc_reg <= FLAG_RESET;
            zero_reg <= FLAG_RESET;
            fw_reg <= WORK_RESET;
            fwe_reg <= 1'b0;
            bad_reg <= 1'b0;
        end
        else
        begin
            work_reg <= work_next;
            carry_reg <= carry_next;
            dc_reg <= dc_next;
            zero_reg <= zero_next;
            fw_reg <= fw_next;
            fwe_reg <= fwe_next;
            bad_reg <= bad_next;
        end
    end

    // ----------------------------------------
    // direction registers
    // ----------------------------------------
    sswd_dir_reg u_dir_a (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .load_i(dir_load[0]),
        .data_i(work_reg), .dir_o(dir_a_o));
    sswd_dir_reg u_dir_b (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .load_i(dir_load[1]),
        .data_i(work_reg), .dir_o(dir_b_o));
    sswd_dir_reg u_dir_c (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .load_i(dir_load[2]),
        .data_i(work_reg), .dir_o(dir_c_o));

    assign work_o = work_reg;
    assign carry_o = carry_reg;
    assign digit_carry_flag_o = dc_reg;
    assign zero_o = zero_reg;
    assign file_wdata_o = fw_reg;
    assign file_we_o = fwe_reg;
    assign bad_dir_o = bad_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_sub_val;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SUB && !dest) |=> work_o == $past(file_rdata_i) - $past(work_reg);
    endproperty
    a_sub_val: assert property (p_sub_val) else $error("subtract value wrong");

    property p_carry;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SUB) |=> carry_o == ($past(file_rdata_i) >= $past(work_reg));
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");

    property p_pos;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SUB && file_rdata_i > work_reg) |=> carry_o && !zero_o;
    endproperty
    a_pos: assert property (p_pos) else $error("positive result flags wrong");

    property p_zero;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SUB) |=> zero_o == ($past(file_rdata_i) == $past(work_reg));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_sub_file;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SUB && dest) |=> file_we_o && $stable(work_o);
    endproperty
    a_sub_file: assert property (p_sub_file) else $error("subtract dest wrong");

    property p_swap;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SWAP) |=> $stable(carry_o) && $stable(zero_o) && $stable(digit_carry_flag_o);
    endproperty
    a_swap: assert property (p_swap) else $error("swap changed flags");

    property p_swap_dst;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_SWAP && dest) |=> file_we_o
            && file_wdata_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])};
    endproperty
    a_swap_dst: assert property (p_swap_dst) else $error("swap write wrong");

    property p_dir;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_DIR && sel == DIR_SEL_B) |=> dir_b_o == $past(work_reg) && !file_we_o;
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");

    property p_one;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (op == SSWD_IDLE) |=> !file_we_o;
    endproperty
    a_one: assert property (p_one) else $error("write outside instruction");
endmodule // sswd_exec

// [inc/sswd_pkg.sv]
package sswd_pkg;
    // ----------------------------------------
    // instruction word layout
    // ----------------------------------------
    localparam int INSTR_W = 12;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int DEST_BIT = 5;
    localparam int ADDR_LSB = 0;
    localparam int SEL_W = 3;
    // ----------------------------------------
    // opcode patterns, upper six bits, upper nine bits for direction load
    // ----------------------------------------
    localparam logic [5:0] OP_SUB_HI = 6'h02;
    localparam logic [5:0] OP_SWAP_HI = 6'h0e;
    localparam logic [8:0] OP_DIR_HI = 9'h000;
    // ----------------------------------------
    // direction register selectors and reset
    // ----------------------------------------
    localparam logic [2:0] DIR_SEL_A = 3'h5;
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    // ----------------------------------------
    // decoder states, one-hot
    // ----------------------------------------
    typedef enum logic [3:0] {
        SSWD_IDLE = 4'h1,
        SSWD_SUB = 4'h2,
        SSWD_SWAP = 4'h4,
        SSWD_DIR = 4'h8
    } sswd_op_t;
endpackage

// [logic/sswd_dir_reg.sv]
`timescale 1ns/1ps
// one port-direction register loaded from the working register
module sswd_dir_reg
    import sswd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [7:0] data_i,
    output logic [7:0] dir_o
);
    logic [7:0] dir_reg; // held direction
    logic [7:0] dir_next; // next direction

    // ----------------------------------------
    // next value
    // ----------------------------------------
    always_comb
    begin
        dir_next = dir_reg;
        if (load_i)
        begin
            dir_next = data_i;
        end
    end

    // ----------------------------------------
    // register
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dir_reg <= DIR_RESET;
        end
        else
        begin
            dir_reg <= dir_next;
        end
    end

    assign dir_o = dir_reg;
endmodule // sswd_dir_reg

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import sswd_pkg::*;
    logic ref_clk_i = 1'b0; // instruction clock
    logic rstn_i = 1'b0; // async reset, active low
    logic instr_valid_i = 1'b0;
    logic [INSTR_W-1:0] instr_i = 12'h000;
    logic [DATA_W-1:0] file_rdata_i = 8'h00;
    logic [ADDR_W-1:0] file_addr_o;
    logic [DATA_W-1:0] file_wdata_o;
    logic file_we_o;
    logic [DATA_W-1:0] work_o;
    logic carry_o;
    logic digit_carry_flag_o;
    logic zero_o;
    logic [7:0] dir_a_o;
    logic [7:0] dir_b_o;
    logic [7:0] dir_c_o;
    logic bad_dir_o;
    int bad_count = 0; // mismatches
    int compares = 0; // comparisons made
    logic [7:0] exp_dir [5:7]; // expected direction registers
    sswd_exec dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o),
        .file_wdata_o(file_wdata_o), .file_we_o(file_we_o), .work_o(work_o),
        .carry_o(carry_o), .digit_carry_flag_o(digit_carry_flag_o), .zero_o(zero_o),
        .dir_a_o(dir_a_o), .dir_b_o(dir_b_o), .dir_c_o(dir_c_o), .bad_dir_o(bad_dir_o));
    // clock, 40 ns period
    always #20 ref_clk_i = ~ref_clk_i;
    // ----------------------------------------
    // compare and drive tasks
    // ----------------------------------------
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one instruction, results checked just after the taking edge
    task automatic exec(input logic [11:0] ins, input logic [7:0] rd);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        file_rdata_i <= rd;
        #1;
        chk8("file_addr", {3'h0, ins[4:0]}, {3'h0, file_addr_o});
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    task automatic chk_flags(input logic c, input logic dc, input logic z);
        chk1("carry", c, carry_o);
        chk1("digit_carry", dc, digit_carry_flag_o);
        chk1("zero", z, zero_o);
    endtask
    task automatic chk_dirs();
        chk8("dir_a", exp_dir[5], dir_a_o);
        chk8("dir_b", exp_dir[6], dir_b_o);
        chk8("dir_c", exp_dir[7], dir_c_o);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog, tests need well under 200 cycles
    initial
    begin
        #(2000 * 40);
        bad_count++;
        finish_test();
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        exp_dir[5] = 8'hff;
        exp_dir[6] = 8'hff;
        exp_dir[7] = 8'hff;
        repeat (16) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        #1;
        chk8("work", 8'h00, work_o);
        chk_flags(1'b0, 1'b0, 1'b0);
        chk1("file_we", 1'b0, file_we_o);
        chk_dirs();
        exec({OP_SWAP_HI, 1'b0, 5'h03}, 8'ha5);
        chk8("work", 8'h5a, work_o);
        chk1("file_we", 1'b0, file_we_o);
        exec({OP_SWAP_HI, 1'b1, 5'h1f}, 8'ha5);
        chk1("file_we", 1'b1, file_we_o);
        chk8("file_wdata", 8'h5a, file_wdata_o);
        exec({OP_SWAP_HI, 1'b0, 5'h00}, 8'h20);
        exec({OP_SUB_HI, 1'b1, 5'h11}, 8'h03);
        chk8("file_wdata", 8'h01, file_wdata_o);
        chk1("file_we", 1'b1, file_we_o);
        chk8("work", 8'h02, work_o);
        chk_flags(1'b1, 1'b1, 1'b0);
        exec({OP_SUB_HI, 1'b1, 5'h11}, 8'h02);
        chk8("file_wdata", 8'h00, file_wdata_o);
        chk_flags(1'b1, 1'b1, 1'b1);
        exec({OP_SWAP_HI, 1'b0, 5'h07}, 8'h10);
        chk_flags(1'b1, 1'b1, 1'b1);
        exec({OP_SUB_HI, 1'b0, 5'h07}, 8'h00);
        chk8("work", 8'hff, work_o);
        chk1("file_we", 1'b0, file_we_o);
        chk_flags(1'b0, 1'b0, 1'b0);
        exec({OP_SWAP_HI, 1'b0, 5'h08}, 8'hf0);
        exec({OP_SUB_HI, 1'b1, 5'h08}, 8'h10);
        chk8("file_wdata", 8'h01, file_wdata_o);
        chk_flags(1'b1, 1'b0, 1'b0);
        // each valid selector gets its own value
        for (int s = 5; s <= 7; s++)
        begin
            exec({OP_SWAP_HI, 1'b0, 5'h02}, {4'h3, s[3:0]});
            exec({OP_DIR_HI, s[2:0]}, 8'h00);
            exp_dir[s] = {s[3:0], 4'h3};
            chk_dirs();
            chk_flags(1'b1, 1'b0, 1'b0);
            chk1("bad_dir", 1'b0, bad_dir_o);
        end
        // selector outside 5..7 changes no direction register, only pulses bad_dir
        exec({OP_DIR_HI, 3'h3}, 8'h00);
        chk1("bad_dir", 1'b1, bad_dir_o);
        chk_dirs();
        @(posedge ref_clk_i);
        #1;
        chk1("bad_dir", 1'b0, bad_dir_o);
        // opcode outside the three is ignored
        exec(12'hfff, 8'h00);
        chk8("work", 8'h73, work_o);
        chk1("file_we", 1'b0, file_we_o);
        // back to back, one result per cycle
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= {OP_SWAP_HI, 1'b0, 5'h09};
        file_rdata_i <= 8'h12;
        @(posedge ref_clk_i);
        instr_i <= {OP_SWAP_HI, 1'b1, 5'h0a};
        file_rdata_i <= 8'h34;
        #1;
        chk8("work", 8'h21, work_o);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        #1;
        chk1("file_we", 1'b1, file_we_o);
        chk8("file_wdata", 8'h43, file_wdata_o);
        chk8("work", 8'h21, work_o);
        @(posedge ref_clk_i);
        #1;
        chk1("file_we", 1'b0, file_we_o);
        finish_test();
    end
endmodule // tb_top
